// [hdl/qenc_front.sv]
// Input synchroniser, edge detector and phase decoder
`timescale 1ns/10ps
module qenc_front
	import qenc_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic phase_first_in,
	input wire logic phase_second_in,
	input wire logic index_in,
	input wire logic invert_first,
	input wire logic invert_second,
	input wire logic invert_index,
	input wire logic phase_swap,
	input wire logic signal_interpretation_sel,
	input wire logic edge_capture_sel,
	qenc_edge_if.front edges
);
	import qenc_pkg::*;

	typedef struct packed {
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [2:0] prev;
		logic pulse;
		logic up;
		logic dir;
		logic dir_chg;
		logic perr;
		logic index;
	} qenc_front_s;

	qenc_front_s state_reg;
	qenc_front_s state_next;
	logic edge_a;
	logic edge_b;
	logic lvl_a;
	logic lvl_b;
	logic e1;
	logic e2;
	logic l1;
	logic l2;
	logic lvl_i;
	logic any_edge;
	logic up_now;

	always_comb
	begin
		state_next = state_reg;
		state_next.sync1 = {index_in, phase_second_in, phase_first_in};
		state_next.sync2 = state_reg.sync1;
		state_next.prev = state_reg.sync2;
		// Edges come from raw synchronised levels, inversion is applied after
		edge_a = state_reg.sync2[0] ^ state_reg.prev[0];
		edge_b = state_reg.sync2[1] ^ state_reg.prev[1];
		lvl_a = state_reg.sync2[0] ^ invert_first;
		lvl_b = state_reg.sync2[1] ^ invert_second;
		lvl_i = state_reg.sync2[2] ^ invert_index;
		e1 = phase_swap ? edge_b : edge_a;
		e2 = phase_swap ? edge_a : edge_b;
		l1 = phase_swap ? lvl_b : lvl_a;
		l2 = phase_swap ? lvl_a : lvl_b;
		any_edge = 1'b0;
		up_now = state_reg.dir;
		state_next.pulse = 1'b0;
		state_next.perr = 1'b0;
		if (signal_interpretation_sel == QENC_SIG_CLKDIR)
		begin
			// Step on rising first input, direction from second level
			any_edge = e1 & l1;
			up_now = l2;
			state_next.pulse = any_edge;
		end
		else if (e1 & e2)
		begin
			// Both phases moved in one sample: order is lost
			state_next.perr = 1'b1;
		end
		else if (e1)
		begin
			any_edge = 1'b1;
			up_now = (l1 != l2);
			state_next.pulse = 1'b1;
		end
		else if (e2)
		begin
			any_edge = 1'b1;
			up_now = (l1 == l2);
			state_next.pulse = (edge_capture_sel != QENC_CAP_FIRST_ONLY);
		end
		// Same phase twice in a row flips the decoded sense
		state_next.dir_chg = any_edge & (up_now != state_reg.dir);
		if (any_edge)
		begin
			state_next.dir = up_now;
		end
		state_next.up = up_now;
		state_next.index = (state_reg.sync2[2] ^ state_reg.prev[2]) & lvl_i;
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign edges.count_pulse = state_reg.pulse;
	assign edges.count_up = state_reg.up;
	assign edges.direction = state_reg.dir;
	assign edges.dir_change = state_reg.dir_chg;
	assign edges.phase_error = state_reg.perr;
	assign edges.index_pulse = state_reg.index;

	default clocking front_cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	AST_DIR_CHANGE_FLIPS: assert property (edges.dir_change |-> edges.direction != $past(edges.direction))
		else $error("direction change without a flip");
	AST_PERR_NO_COUNT: assert property (edges.phase_error |-> !edges.count_pulse)
		else $error("count on a phase error");
endmodule

// [hdl/qenc_top.sv]
// Quadrature encoder position integrator and velocity capture
// Function
// - Position and velocity enable separately; velocity runs only with position enabled.
// - Phase exchange swaps the two phases before decoding, reversing count sense.
// - Interpretation zero decodes quadrature phases, direction from edge order.
// - Interpretation one uses first input as step clock, second as direction.
// - Capture zero counts first phase edges only; one counts both phases.
// - First phase leading second phase increments the position.
// - Second phase leading first phase decrements the position.
// - Two edges on one phase with none between flag a direction change.
// - Reset selection one clears position on each sensed index pulse.
// - Counting down from zero loads the programmed maximum.
// - Reset selection zero keeps position within zero to maximum, ignores index.
// - After an index, index mode position is the angle from the index.
// - Velocity counts edges with the same selection as the position.
// - Timer counts down, flags expiry at zero, reloads and continues.
// - Edges are divided by two to the predivide power before accumulating.
// - Predivide codes zero to seven give division by one up to 128.
// - Separate events for phase error, direction change, index and timer expiry.
// - Per-event mask, raw status, masked status and per-event clear.
`timescale 1ns/10ps
module qenc_top
	import qenc_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic phase_first_in,
	input wire logic phase_second_in,
	input wire logic index_in,
	input wire logic encoder_enable,
	input wire logic velocity_enable,
	input wire logic phase_swap,
	input wire logic signal_interpretation_sel,
	input wire logic edge_capture_sel,
	input wire logic count_reset_sel,
	input wire qenc_pkg::qenc_div_t velocity_predivide,
	input wire logic invert_first,
	input wire logic invert_second,
	input wire logic invert_index,
	input wire qenc_pkg::qenc_word_t position_maximum,
	input wire qenc_pkg::qenc_word_t period_reload,
	input wire qenc_pkg::qenc_evt_t event_mask,
	input wire qenc_pkg::qenc_evt_t event_clear,
	output logic direction,
	output qenc_pkg::qenc_word_t position_value,
	output qenc_pkg::qenc_word_t speed_result,
	output qenc_pkg::qenc_word_t edge_accumulator,
	output qenc_pkg::qenc_word_t timer_value,
	output qenc_pkg::qenc_evt_t raw_status,
	output qenc_pkg::qenc_evt_t masked_status,
	output logic event_out
);
	import qenc_pkg::*;

	typedef struct packed {
		qenc_word_t pos;
		qenc_word_t speed;
		qenc_word_t acc;
		qenc_word_t timer;
		qenc_pre_t pre;
		qenc_evt_t raw;
		qenc_evt_t masked;
		logic evt;
	} qenc_core_s;

	qenc_core_s state_reg;
	qenc_core_s state_next;
	qenc_edge_if edges ();

	logic pos_active;
	logic vel_active;
	logic counted;
	logic index_reset;
	logic divided;
	logic timer_expired;
	qenc_pre_t pre_limit;
	qenc_evt_t evt_set;

	qenc_front u_front
	(
		.clock(clock),
		.rst_b(rst_b),
		.phase_first_in(phase_first_in),
		.phase_second_in(phase_second_in),
		.index_in(index_in),
		.invert_first(invert_first),
		.invert_second(invert_second),
		.invert_index(invert_index),
		.phase_swap(phase_swap),
		.signal_interpretation_sel(signal_interpretation_sel),
		.edge_capture_sel(edge_capture_sel),
		.edges(edges.front)
	);

	always_comb
	begin
		state_next = state_reg;
		pos_active = encoder_enable;
		vel_active = encoder_enable & velocity_enable;
		counted = pos_active & edges.count_pulse;
		index_reset = pos_active & (count_reset_sel == QENC_RES_AT_INDEX) & edges.index_pulse;
		// Position integrator; index clear wins over an edge in the same cycle
		if (index_reset)
		begin
			state_next.pos = QENC_POS_RESET;
		end
		else if (counted && edges.count_up)
		begin
			if (state_reg.pos >= position_maximum)
			begin
				state_next.pos = QENC_POS_RESET;
			end
			else
			begin
				state_next.pos = state_reg.pos + 32'h1;
			end
		end
		else if (counted)
		begin
			if (state_reg.pos == QENC_POS_RESET)
			begin
				state_next.pos = position_maximum;
			end
			else if (state_reg.pos > position_maximum)
			begin
				state_next.pos = position_maximum;
			end
			else
			begin
				state_next.pos = state_reg.pos - 32'h1;
			end
		end
		// Predivider: limit is two to the code, minus one
		pre_limit = QENC_PRE_W'((8'h1 << velocity_predivide) - 8'h1);
		divided = 1'b0;
		timer_expired = 1'b0;
		if (!vel_active)
		begin
			// Idle capture restarts a full period once enabled
			state_next.pre = QENC_PRE_RESET;
			state_next.acc = QENC_ACC_RESET;
			state_next.timer = period_reload;
		end
		else
		begin
			if (counted)
			begin
				if (state_reg.pre == pre_limit)
				begin
					divided = 1'b1;
					state_next.pre = QENC_PRE_RESET;
				end
				else
				begin
					state_next.pre = state_reg.pre + 7'h1;
				end
			end
			if (state_reg.timer == QENC_TIMER_RESET)
			begin
				timer_expired = 1'b1;
				state_next.timer = period_reload;
				state_next.speed = state_reg.acc;
				// An edge in the expiry cycle opens the new period
				state_next.acc = divided ? 32'h1 : QENC_ACC_RESET;
			end
			else
			begin
				state_next.timer = state_reg.timer - 32'h1;
				if (divided)
				begin
					state_next.acc = state_reg.acc + 32'h1;
				end
			end
		end
		// Sticky events; a new event beats a clear in the same cycle
		evt_set = '0;
		evt_set[QENC_EVT_PHASE_ERR] = pos_active & edges.phase_error;
		evt_set[QENC_EVT_DIR_CHANGE] = pos_active & edges.dir_change;
		evt_set[QENC_EVT_INDEX] = pos_active & edges.index_pulse;
		evt_set[QENC_EVT_TIMER] = timer_expired;
		state_next.raw = (state_reg.raw & ~event_clear) | evt_set;
		state_next.masked = state_next.raw & event_mask;
		state_next.evt = |state_next.masked;
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg.pos <= QENC_POS_RESET;
			state_reg.speed <= QENC_SPEED_RESET;
			state_reg.acc <= QENC_ACC_RESET;
			state_reg.timer <= QENC_TIMER_RESET;
			state_reg.pre <= QENC_PRE_RESET;
			state_reg.raw <= QENC_EVT_RESET;
			state_reg.masked <= QENC_EVT_RESET;
			state_reg.evt <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// Direction is a flip-flop inside the front end
	assign direction = edges.direction;
	assign position_value = state_reg.pos;
	assign speed_result = state_reg.speed;
	assign edge_accumulator = state_reg.acc;
	assign timer_value = state_reg.timer;
	assign raw_status = state_reg.raw;
	assign masked_status = state_reg.masked;
	assign event_out = state_reg.evt;

	default clocking core_cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	sequence seq_period_end;
		vel_active && (state_reg.timer == QENC_TIMER_RESET);
	endsequence

	sequence seq_reloaded;
		(timer_value == $past(period_reload)) && (speed_result == $past(state_reg.acc));
	endsequence

	sequence seq_count_down_step;
		vel_active && (state_reg.timer != QENC_TIMER_RESET);
	endsequence

	AST_VEL_NEEDS_POS: assert property (!encoder_enable |=> edge_accumulator == 32'h0)
		else $error("accumulator moved while position disabled");
	AST_INCREMENT: assert property (counted && edges.count_up && !index_reset
		&& state_reg.pos < position_maximum |=> position_value == $past(position_value) + 32'h1)
		else $error("position did not increment");
	AST_DECREMENT: assert property (counted && !edges.count_up && !index_reset
		&& state_reg.pos != 32'h0 && state_reg.pos <= position_maximum
		|=> position_value == $past(position_value) - 32'h1)
		else $error("position did not decrement");
	AST_WRAP_DOWN: assert property (counted && !edges.count_up && !index_reset
		&& state_reg.pos == 32'h0 |=> position_value == $past(position_maximum))
		else $error("backward count from zero did not load maximum");
	AST_WRAP_UP: assert property (counted && edges.count_up && !index_reset
		&& state_reg.pos >= position_maximum |=> position_value == 32'h0)
		else $error("forward count at maximum did not wrap");
	AST_INDEX_CLEAR: assert property (index_reset |=> position_value == 32'h0)
		else $error("index did not clear position");
	AST_INDEX_IGNORED: assert property (encoder_enable && !count_reset_sel && edges.index_pulse
		&& !edges.count_pulse |=> $stable(position_value))
		else $error("index moved position in maximum mode");
	AST_PERIOD_END: assert property (seq_period_end |=> seq_reloaded)
		else $error("period end did not reload timer and latch speed");
	AST_TIMER_DOWN: assert property (seq_count_down_step
		|=> timer_value == $past(timer_value) - 32'h1)
		else $error("timer did not count down");
	AST_EXPIRY_EVENT: assert property (seq_period_end |=> raw_status[QENC_EVT_TIMER])
		else $error("timer expiry not flagged");
	AST_NO_PREDIVIDE: assert property (seq_count_down_step and (counted && velocity_predivide == 3'h0)
		|=> edge_accumulator == $past(edge_accumulator) + 32'h1)
		else $error("undivided edge not accumulated");
	AST_SET_BEATS_CLEAR: assert property (encoder_enable && edges.phase_error
		|=> raw_status[QENC_EVT_PHASE_ERR])
		else $error("phase error lost");
	AST_MASKED_VIEW: assert property (masked_status == (raw_status & $past(event_mask)))
		else $error("masked status wrong");
	AST_EVENT_LINE: assert property (event_out == (masked_status != 4'h0))
		else $error("event line disagrees with masked status");
endmodule

// [include/qenc_edge_if.sv]
// Decoded edge events passed from the input front end to the core
`timescale 1ns/10ps
interface qenc_edge_if;
	logic count_pulse;
	logic count_up;
	logic direction;
	logic dir_change;
	logic phase_error;
	logic index_pulse;
	modport front
	(
		output count_pulse,
		output count_up,
		output direction,
		output dir_change,
		output phase_error,
		output index_pulse
	);
	modport core
	(
		input count_pulse,
		input count_up,
		input direction,
		input dir_change,
		input phase_error,
		input index_pulse
	);
endinterface

// [include/qenc_pkg.sv]
// Constants and types shared by the encoder interface modules
package qenc_pkg;
	localparam int QENC_POS_W = 32;
	localparam int QENC_DIV_W = 3;
	localparam int QENC_PRE_W = 7;
	localparam int QENC_EVT_N = 4;
	localparam int QENC_SYNC_STAGES = 2;
	localparam int QENC_EVT_PHASE_ERR = 0;
	localparam int QENC_EVT_DIR_CHANGE = 1;
	localparam int QENC_EVT_INDEX = 2;
	localparam int QENC_EVT_TIMER = 3;
	typedef logic [QENC_POS_W-1:0] qenc_word_t;
	typedef logic [QENC_EVT_N-1:0] qenc_evt_t;
	typedef logic [QENC_DIV_W-1:0] qenc_div_t;
	typedef logic [QENC_PRE_W-1:0] qenc_pre_t;
	localparam qenc_word_t QENC_POS_RESET = 32'h0;
	localparam qenc_word_t QENC_SPEED_RESET = 32'h0;
	localparam qenc_word_t QENC_ACC_RESET = 32'h0;
	localparam qenc_word_t QENC_TIMER_RESET = 32'h0;
	localparam qenc_pre_t QENC_PRE_RESET = 7'h0;
	localparam qenc_evt_t QENC_EVT_RESET = 4'h0;
	localparam logic QENC_SIG_QUAD = 1'b0;
	localparam logic QENC_SIG_CLKDIR = 1'b1;
	localparam logic QENC_CAP_FIRST_ONLY = 1'b0;
	localparam logic QENC_RES_AT_MAX = 1'b0;
	localparam logic QENC_RES_AT_INDEX = 1'b1;
endpackage

// [testbench/qenc_encoder_model.sv]
// Encoder model: quadrature or step/direction pins and an index pulse
`timescale 1ns/10ps
module qenc_encoder_model
(
	input wire logic clock,
	input wire logic step_req,
	input wire logic step_dir,
	input wire logic clkdir_mode,
	input wire logic glitch_req,
	input wire logic index_req,
	output logic phase_first_in,
	output logic phase_second_in,
	output logic index_in
);
	int index_left;
	initial
	begin
		phase_first_in = 1'b0;
		phase_second_in = 1'b0;
		index_in = 1'b0;
		index_left = 0;
	end
	// Pins move on the falling edge so the block never samples them mid-change
	always @(negedge clock)
	begin
		if (clkdir_mode)
			phase_second_in <= step_dir;
		if (step_req && clkdir_mode)
			phase_first_in <= !phase_first_in;
		else if (step_req && (step_dir ^ (phase_first_in != phase_second_in)))
			phase_first_in <= !phase_first_in;
		else if (step_req)
			phase_second_in <= !phase_second_in;
		if (glitch_req)
		begin
			phase_first_in <= !phase_first_in;
			phase_second_in <= !phase_second_in;
		end
		if (index_req)
		begin
			index_in <= 1'b1;
			index_left <= 3;
		end
		else if (index_left > 0)
			index_left <= index_left - 1;
		else
			index_in <= 1'b0;
	end
endmodule

// [testbench/qenc_top_tb.sv]
// Self-checking bench for the encoder interface top
`timescale 1ns/10ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
	$display("Error at %0t ns: got %h expected %h", $time, got, exp); end end
module qenc_top_tb;
	import qenc_pkg::*;
	logic clock, rst_b, phase_first_in, phase_second_in, index_in, direction, event_out;
	logic encoder_enable, velocity_enable, phase_swap, signal_interpretation_sel;
	logic edge_capture_sel, count_reset_sel, step_req, step_dir, glitch_req, index_req, a, b;
	qenc_div_t velocity_predivide;
	qenc_word_t position_maximum, period_reload, position_value, speed_result;
	qenc_word_t edge_accumulator, timer_value, prev_pos, pos, exp_v;
	qenc_evt_t event_mask, event_clear, raw_status, masked_status;
	int num_errors, tests_run, seed, n, k;
	qenc_word_t exp_q[$];

	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	qenc_top i_qenc_top (.clock(clock), .rst_b(rst_b), .phase_first_in(phase_first_in),
		.phase_second_in(phase_second_in), .index_in(index_in), .encoder_enable(encoder_enable),
		.velocity_enable(velocity_enable), .phase_swap(phase_swap),
		.signal_interpretation_sel(signal_interpretation_sel), .edge_capture_sel(edge_capture_sel),
		.count_reset_sel(count_reset_sel), .velocity_predivide(velocity_predivide),
		.invert_first(1'b0), .invert_second(1'b0), .invert_index(1'b0),
		.position_maximum(position_maximum), .period_reload(period_reload),
		.event_mask(event_mask), .event_clear(event_clear), .direction(direction),
		.position_value(position_value), .speed_result(speed_result),
		.edge_accumulator(edge_accumulator), .timer_value(timer_value),
		.raw_status(raw_status), .masked_status(masked_status), .event_out(event_out));

	qenc_encoder_model i_qenc_encoder_model (.clock(clock), .step_req(step_req),
		.step_dir(step_dir), .clkdir_mode(signal_interpretation_sel), .glitch_req(glitch_req),
		.index_req(index_req), .phase_first_in(phase_first_in),
		.phase_second_in(phase_second_in), .index_in(index_in));

	// Every position change must match the oldest note, so silent extra counts show up
	always @(negedge clock)
	begin
		if (rst_b !== 1'b1)
			prev_pos = '0;
		else if (position_value !== prev_pos)
		begin
			prev_pos = position_value;
			`CHK(exp_q.size() > 0, 1'b1)
			if (exp_q.size() > 0)
			begin
				exp_v = exp_q.pop_front();
				`CHK(position_value, exp_v)
			end
		end
	end

	task end_sim;
		$display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task clr(input qenc_evt_t m);
		event_clear <= m;
		@(negedge clock);
		event_clear <= '0;
	endtask

	task step(input logic up);
		logic cnt, eu;
		step_dir <= up;
		repeat (3) @(negedge clock);
		step_req <= 1'b1;
		@(negedge clock);
		step_req <= 1'b0;
		if (signal_interpretation_sel)
		begin
			cnt = !a;
			eu = up;
			a = !a;
			b = up;
		end
		else
		begin
			cnt = edge_capture_sel | (up == (a == b));
			eu = up ^ phase_swap;
			if (up == (a == b))
				a = !a;
			else
				b = !b;
		end
		if (cnt && encoder_enable)
		begin
			if (eu)
				pos = (pos == position_maximum) ? '0 : pos + 32'h1;
			else
				pos = (pos == '0) ? position_maximum : pos - 32'h1;
			exp_q.push_back(pos);
		end
		repeat (6) @(negedge clock);
	endtask

	task pulse_other(input logic glitch);
		if (glitch)
			glitch_req <= 1'b1;
		else
			index_req <= 1'b1;
		@(negedge clock);
		glitch_req <= 1'b0;
		index_req <= 1'b0;
		if (glitch)
		begin
			a = !a;
			b = !b;
		end
		else if (count_reset_sel && encoder_enable && pos != '0)
		begin
			pos = '0;
			exp_q.push_back(pos);
		end
		repeat (8) @(negedge clock);
	endtask

	// Bounded wait for an event bit; the bit is cleared first so only a fresh one counts
	task wait_evt(input int bit_n, output int cycles);
		event_clear[bit_n] <= 1'b1;
		@(negedge clock);
		event_clear <= '0;
		cycles = 1;
		while (raw_status[bit_n] !== 1'b1 && cycles < 2000)
		begin
			@(negedge clock);
			cycles++;
		end
		if (cycles >= 2000)
		begin
			num_errors++;
			end_sim();
		end
	endtask

	initial
	begin
		{encoder_enable, velocity_enable, phase_swap, signal_interpretation_sel} = '0;
		{edge_capture_sel, count_reset_sel, step_req, step_dir, glitch_req, index_req} = '0;
		{a, b, num_errors, tests_run} = '0;
		velocity_predivide = '0;
		event_mask = '0;
		event_clear = '0;
		period_reload = 32'd200;
		pos = '0;
		seed = 32'h02cc;
		rst_b = 1'b0;
		repeat (16) @(negedge clock);
		rst_b = 1'b1;
		edge_capture_sel = 1'b1;
		position_maximum = 32'(3 + ($random(seed) & 7));
		encoder_enable = 1'b1;
		repeat (40) step(1'($random(seed)));
		step(1'b1);
		clr(4'hf);
		step(1'b1);
		`CHK(raw_status[1], 1'b0)
		step(1'b0);
		`CHK(raw_status[1], 1'b1)
		`CHK(direction, 1'b0)
		repeat (int'(position_maximum) + 2) step(1'b0);
		step(1'b1);
		`CHK(direction, 1'b1)
		clr(4'hf);
		pulse_other(1'b1);
		`CHK(raw_status[0], 1'b1)
		clr(4'hf);
		event_mask = 4'h4;
		pulse_other(1'b0);
		`CHK(raw_status, 4'h4)
		`CHK(masked_status, 4'h4)
		`CHK(event_out, 1'b1)
		clr(4'h4);
		@(negedge clock);
		`CHK(event_out, 1'b0)
		if (pos == '0)
			step(1'b1);
		count_reset_sel = 1'b1;
		position_maximum = 32'd11;
		pulse_other(1'b0);
		step(1'b0);
		repeat (4) step(1'b1);
		`CHK(position_value, 32'd3)
		count_reset_sel = 1'b0;
		edge_capture_sel = 1'b0;
		repeat (4) step(1'b1);
		edge_capture_sel = 1'b1;
		phase_swap = 1'b1;
		repeat (3) step(1'b1);
		`CHK(direction, 1'b0)
		phase_swap = 1'b0;
		encoder_enable = 1'b0;
		repeat (3) step(1'b1);
		encoder_enable = 1'b1;
		signal_interpretation_sel = 1'b1;
		repeat (6) step(1'b1);
		repeat (6) step(1'b0);
		signal_interpretation_sel = 1'b0;
		for (k = 0; k < 8; k++)
		begin
			edge_capture_sel = 1'(k);
			velocity_predivide = 3'(k);
			velocity_enable = 1'b1;
			repeat (12) step(1'b1);
			wait_evt(3, n);
			`CHK(speed_result, 32'((edge_capture_sel ? 12 : 6) >> k))
			wait_evt(3, n);
			`CHK(n, 201)
			`CHK(speed_result, 32'h0)
			velocity_enable = 1'b0;
			@(negedge clock);
		end
		encoder_enable = 1'b0;
		velocity_enable = 1'b1;
		clr(4'h8);
		repeat (300) @(negedge clock);
		`CHK(raw_status[3], 1'b0)
		`CHK(exp_q.size(), 0)
		end_sim();
	end
endmodule
